/* File: haptic_adc_pkg.sv */
package haptic_adc_pkg;
	localparam int          CLK_MHZ       = 200;
	// Register byte offsets.
	localparam logic [7:0]  OFS_CTRL      = 8'h00;
	localparam logic [7:0]  OFS_GUESS     = 8'h04;
	localparam logic [7:0]  OFS_BRAKE     = 8'h08;
	localparam logic [7:0]  OFS_ABRK      = 8'h0c;
	localparam logic [7:0]  OFS_DRIVE     = 8'h10;
	localparam logic [7:0]  OFS_ADC_CTRL  = 8'h14;
	localparam logic [7:0]  OFS_ADC_STAT  = 8'h18;
	localparam logic [7:0]  OFS_ADC_RES   = 8'h1c;
	localparam logic [7:0]  OFS_TRACK     = 8'h20;
	// Control register bits.
	localparam int          BIT_TYPE      = 0;
	localparam int          BIT_TRACK     = 1;
	localparam int          BIT_ALC       = 2;
	localparam int          BIT_RAM       = 3;
	localparam int          BIT_TRG       = 4;
	localparam int          BIT_POINTS    = 5;
	localparam int          BIT_DRIVE     = 6;
	localparam int          BIT_BRKAMP    = 7;
	localparam int          POS_SKIP      = 8;
	// Brake register fields, four bits each.
	localparam int          POS_BRK_GAIN  = 0;
	localparam int          POS_BRK_CYC   = 8;
	localparam int          POS_BRK_WDW   = 16;
	localparam int          POS_NRM_GAIN  = 20;
	localparam int          POS_NRM_WDW   = 24;
	// Autobrake register fields.
	localparam int          POS_AB_THR    = 0;
	localparam int          POS_AB_WDW    = 8;
	localparam int          POS_AB_CONS   = 16;
	// Drive register fields.
	localparam int          POS_AMP       = 0;
	localparam int          BIT_DIR       = 7;
	localparam int          POS_SCODE     = 8;
	localparam int          POS_SRPT      = 12;
	localparam int          POS_VFS       = 24;
	// Converter control and status fields.
	localparam int          POS_CHAN      = 0;
	localparam int          POS_AVG       = 4;
	localparam int          BIT_LAUNCH    = 8;
	localparam int          POS_RATIO     = 16;
	localparam int          BIT_DONE      = 0;
	localparam int          BIT_BUSY      = 1;
	localparam int          BIT_BADMON    = 2;
	localparam int          POS_FSMV      = 16;
	// Reset values.
	localparam logic [31:0] CTRL_RST      = 32'h0000_0002;
	localparam logic [31:0] GUESS_RST     = 32'h0000_0190;
	localparam logic [31:0] BRAKE_RST     = 32'h0210_0202;
	localparam logic [31:0] ABRK_RST      = 32'h0002_1010;
	localparam logic [31:0] DRIVE_RST     = 32'hff00_0000;
	localparam logic [31:0] ADC_CTRL_RST  = 32'h0000_0000;
	// Converter channels and full-scale values in millivolts.
	localparam logic [2:0]  CH_SUPPLY     = 3'h0;
	localparam logic [2:0]  CH_MONITOR    = 3'h1;
	localparam logic [2:0]  CH_CHARGER    = 3'h2;
	localparam logic [2:0]  CH_PUMP       = 3'h3;
	localparam logic [2:0]  CH_BOOST      = 3'h4;
	localparam logic [15:0] FS_LOW_MV     = 16'd5500;
	localparam logic [15:0] FS_MID_MV     = 16'd8250;
	localparam logic [15:0] FS_HIGH_MV    = 16'd21000;
	localparam logic [1:0]  RATIO_UNITY   = 2'h0;
	// Resonance limits: frequency figures and cycles per period; then the supply poll interval in microseconds and cycles.
	localparam int          SLOW_KHZ      = 200;
	localparam int          FAST_KHZ      = 800;
	localparam int          INIT_KHZ      = 400;
	localparam int          FLOOR_HZ      = 100;
	localparam int          CEIL_HZ       = 1000;
	localparam int          CYC_SLOW      = CLK_MHZ * 1000 / SLOW_KHZ;
	localparam int          CYC_FAST      = CLK_MHZ * 1000 / FAST_KHZ;
	localparam int          CYC_INIT      = CLK_MHZ * 1000 / INIT_KHZ;
	localparam int          PER_MAX_CYC   = CLK_MHZ * 1000000 / FLOOR_HZ;
	localparam int          PER_MIN_CYC   = CLK_MHZ * 1000000 / CEIL_HZ;
	localparam int          POLL_US       = 100;
	localparam int          POLL_CYC      = POLL_US * CLK_MHZ;
	typedef enum logic [1:0] {ADC_IDLE, ADC_START, ADC_WAIT} adc_state_t;
endpackage

/* File: haptic_drive_and_adc_control.sv */
// Our own choices: the Wishbone interface to the registers and the placing of the registers.
`timescale 1ns/1ps
module haptic_drive_and_adc_control
	import haptic_adc_pkg::*;
#(
	parameter int PER_MAX  = PER_MAX_CYC,
	parameter int PER_MIN  = PER_MIN_CYC,
	parameter int POLL_MAX = POLL_CYC
)(
	input  wire logic        ref_clk,
	input  wire logic        rst_n,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	output logic             adcStart,
	output logic      [2:0]  adcChannel,
	input  wire logic        adcReady,
	input  wire logic [7:0]  adcData,
	input  wire logic        bemfValid,
	input  wire logic [7:0]  bemfData,
	output logic             drvP,
	output logic             drvN
);
	logic [31:0] ctrlQ, guessQ, brakeQ, abrkQ, driveQ, adcCtrlQ;
	logic        ackQ, req, wr;
	logic [1:0]  rdySync, vldSync;
	logic        rdyPrev, vldPrev, rdyEdge, bemfStrobe;
	logic [7:0]  adcD1, adcD2, bemfD1, bemfD2;
	adc_state_t  stateQ;
	logic        manualQ, doneQ, launchReq, doneClr, doneSet, pollPend;
	logic [7:0]  leftQ, avgQ, minQ, maxQ, supplyQ, avgNow;
	logic [14:0] sumQ, sumNext;
	logic [2:0]  chanQ;
	logic [31:0] pollCnt;
	logic [23:0] periodQ, loPer, hiPer, measPer;
	logic [23:0] halfCnt;
	logic [17:0] segCnt;
	logic [5:0]  idxQ;
	logic        halfEnd, prevSign, crossing, dirPrev;
	logic [3:0]  brakeLeft, gainEff, wdwEff;
	logic        brakeActive, driving, isLra;
	logic        brakeSample, pointHit, abStopQ;
	logic [7:0]  winLeft, lowCnt, lowNow;
	logic [3:0]  quietRun;
	logic [7:0]  target, duty, mag, pwmCnt;
	logic [15:0] dutyWide;
	logic        polPos;

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] dat,
		input logic [3:0] sel);
		logic [31:0] res;
		res = old;
		for (int b = 0; b < 4; b++)
		begin
			if (sel[b])
				res[8*b +: 8] = dat[8*b +: 8];
		end
		return res;
	endfunction

	function automatic logic [23:0] clampPer(input logic [23:0] p, input logic [23:0] lo,
		input logic [23:0] hi);
		return (p < lo) ? lo : ((p > hi) ? hi : p);
	endfunction

	function automatic logic [7:0] sineAt(input logic [5:0] idx);
		logic [3:0] k;
		k = idx[4] ? ~idx[3:0] : idx[3:0];
		case (k)
			4'h0: return 8'h0d;
			4'h1: return 8'h25;
			4'h2: return 8'h3e;
			4'h3: return 8'h56;
			4'h4: return 8'h6d;
			4'h5: return 8'h83;
			4'h6: return 8'h98;
			4'h7: return 8'hab;
			4'h8: return 8'hbd;
			4'h9: return 8'hcd;
			4'ha: return 8'hdb;
			4'hb: return 8'he7;
			4'hc: return 8'hf0;
			4'hd: return 8'hf7;
			4'he: return 8'hfc;
			default: return 8'hff;
		endcase
	endfunction

	function automatic logic [15:0] fullScaleMv(input logic [2:0] ch);
		case (ch)
			CH_SUPPLY, CH_MONITOR: return FS_LOW_MV;
			CH_CHARGER, CH_PUMP:   return FS_MID_MV;
			CH_BOOST:              return FS_HIGH_MV;
			default:               return 16'h0000;
		endcase
	endfunction

	// Bus slave: one wait state, every access is acknowledged.
	assign req       = wb_cyc_i && wb_stb_i && !ackQ;
	assign wr        = req && wb_we_i;
	assign wb_ack_o  = ackQ;
	assign launchReq = wr && (wb_adr_i == OFS_ADC_CTRL) && wb_sel_i[1] && wb_dat_i[BIT_LAUNCH];
	assign doneClr   = wr && (wb_adr_i == OFS_ADC_STAT) && wb_sel_i[0] && wb_dat_i[BIT_DONE];

	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			ackQ     <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end
		else
		begin
			ackQ     <= req;
			wb_dat_o <= 32'h0000_0000;
			if (req && !wb_we_i)
			begin
				case (wb_adr_i)
					OFS_CTRL:     wb_dat_o <= {20'h00000, ctrlQ[11:0]};
					OFS_GUESS:    wb_dat_o <= {20'h00000, guessQ[11:0]};
					OFS_BRAKE:    wb_dat_o <= {4'h0, brakeQ[27:0]};
					OFS_ABRK:     wb_dat_o <= {12'h000, abrkQ[19:0]};
					OFS_DRIVE:    wb_dat_o <= {driveQ[31:24], 8'h00, driveQ[15:0]};
					OFS_ADC_CTRL: wb_dat_o <= {14'h0000, adcCtrlQ[17:16], 9'h000, adcCtrlQ[6:0]};
					// Full scale of the selected channel.
					// Monitor flag when the divider is not unity.
					OFS_ADC_STAT: wb_dat_o <= {fullScaleMv(adcCtrlQ[2:0]), 13'h0000,
						(adcCtrlQ[2:0] == CH_MONITOR) && (adcCtrlQ[17:16] != RATIO_UNITY),
						stateQ != ADC_IDLE, doneQ};
					OFS_ADC_RES:  wb_dat_o <= {supplyQ, maxQ, minQ, avgQ};
					OFS_TRACK:    wb_dat_o <= {4'h0, quietRun, abStopQ, brakeActive,
						periodQ[23:2]};
					default:      wb_dat_o <= 32'h0000_0000;
				endcase
			end
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			ctrlQ    <= CTRL_RST;
			guessQ   <= GUESS_RST;
			brakeQ   <= BRAKE_RST;
			abrkQ    <= ABRK_RST;
			driveQ   <= DRIVE_RST;
			adcCtrlQ <= ADC_CTRL_RST;
		end
		else if (wr)
		begin
			case (wb_adr_i)
				OFS_CTRL:     ctrlQ    <= merge(ctrlQ, wb_dat_i, wb_sel_i);
				OFS_GUESS:    guessQ   <= merge(guessQ, wb_dat_i, wb_sel_i);
				OFS_BRAKE:    brakeQ   <= merge(brakeQ, wb_dat_i, wb_sel_i);
				OFS_ABRK:     abrkQ    <= merge(abrkQ, wb_dat_i, wb_sel_i);
				OFS_DRIVE:    driveQ   <= merge(driveQ, wb_dat_i, wb_sel_i);
				OFS_ADC_CTRL: adcCtrlQ <= merge(adcCtrlQ, wb_dat_i, wb_sel_i);
				default:      ctrlQ    <= ctrlQ;
			endcase
		end
	end

	// Pins from the converter and sense amplifier come from another timing domain.
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rdySync <= 2'h0;
			vldSync <= 2'h0;
			rdyPrev <= 1'b0;
			vldPrev <= 1'b0;
			adcD1   <= 8'h00;
			adcD2   <= 8'h00;
			bemfD1  <= 8'h00;
			bemfD2  <= 8'h00;
		end
		else
		begin
			rdySync <= {rdySync[0], adcReady};
			vldSync <= {vldSync[0], bemfValid};
			rdyPrev <= rdySync[1];
			vldPrev <= vldSync[1];
			adcD1   <= adcData;
			adcD2   <= adcD1;
			bemfD1  <= bemfData;
			bemfD2  <= bemfD1;
		end
	end
	assign rdyEdge    = rdySync[1] && !rdyPrev;
	assign bemfStrobe = vldSync[1] && !vldPrev;

	// Accumulate and divide by the power-of-two sample count.
	assign sumNext    = sumQ + {7'h00, adcD2};
	assign avgNow     = 8'(sumNext >> adcCtrlQ[POS_AVG +: 3]);
	assign adcStart   = (stateQ == ADC_START);
	assign adcChannel = chanQ;
	assign doneSet    = (stateQ == ADC_WAIT) && rdyEdge && (leftQ == 8'h00) && manualQ;

	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			stateQ  <= ADC_IDLE;
			manualQ <= 1'b0;
			chanQ   <= CH_SUPPLY;
			leftQ   <= 8'h00;
			sumQ    <= 15'h0000;
			avgQ    <= 8'h00;
			minQ    <= 8'h00;
			maxQ    <= 8'h00;
			supplyQ <= 8'hff;
		end
		else
		begin
			case (stateQ)
				ADC_IDLE:
				begin
					sumQ  <= 15'h0000;
					leftQ <= 8'((16'h0001 << adcCtrlQ[POS_AVG +: 3]) - 16'h0001);
					// Manual launch on the selected channel.
					if (launchReq)
					begin
						manualQ <= 1'b1;
						chanQ   <= adcCtrlQ[POS_CHAN +: 3];
						// An empty sum cannot mark the first sample, since a zero sample keeps it empty.
						minQ    <= 8'hff;
						maxQ    <= 8'h00;
						stateQ  <= ADC_START;
					end
					else if (pollPend)
					begin
						manualQ <= 1'b0;
						chanQ   <= CH_SUPPLY;
						stateQ  <= ADC_START;
					end
				end
				ADC_START:
					stateQ <= ADC_WAIT;
				ADC_WAIT:
				begin
					if (rdyEdge)
					begin
						sumQ  <= sumNext;
						leftQ <= leftQ - 8'h01;
						// Running minimum and maximum for the report.
						if (manualQ)
						begin
							minQ <= (adcD2 < minQ) ? adcD2 : minQ;
							maxQ <= (adcD2 > maxQ) ? adcD2 : maxQ;
						end
						stateQ <= (leftQ == 8'h00) ? ADC_IDLE : ADC_START;
						if (leftQ == 8'h00 && manualQ)
							avgQ <= avgNow;
						if (leftQ == 8'h00 && !manualQ)
							supplyQ <= avgNow;
					end
				end
				default:
					stateQ <= ADC_IDLE;
			endcase
		end
	end

	// A launch while busy is dropped, not queued.
	// Set wins over a clear in the same cycle.
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
			doneQ <= 1'b0;
		else if (doneSet)
			doneQ <= 1'b1;
		else if (doneClr)
			doneQ <= 1'b0;
	end

	// Supply is polled only while compensation and drive are on.
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			pollCnt  <= 32'h0000_0000;
			pollPend <= 1'b0;
		end
		else
		begin
			pollCnt <= (ctrlQ[BIT_ALC] && driving && pollCnt < POLL_MAX - 1) ?
				pollCnt + 32'h0000_0001 : 32'h0000_0000;
			if (ctrlQ[BIT_ALC] && driving && pollCnt == POLL_MAX - 1)
				pollPend <= 1'b1;
			else if (stateQ == ADC_IDLE && !launchReq)
				pollPend <= 1'b0;
		end
	end

	// Type select picks the waveform below.
	assign isLra   = ctrlQ[BIT_TYPE];
	assign driving = ctrlQ[BIT_DRIVE] && !abStopQ;
	// Slowest period from guess and floor frequency.
	assign hiPer   = (24'(guessQ[11:0] * CYC_SLOW) < 24'(PER_MAX)) ?
		24'(guessQ[11:0] * CYC_SLOW) : 24'(PER_MAX);
	// Fastest period from guess and ceiling frequency.
	assign loPer   = (24'(guessQ[11:0] * CYC_FAST) > 24'(PER_MIN)) ?
		24'(guessQ[11:0] * CYC_FAST) : 24'(PER_MIN);
	assign halfEnd = (segCnt == 18'h00000) && (idxQ[4:0] == 5'h1f);
	assign crossing = bemfStrobe && (bemfD2[7] != prevSign);
	assign measPer  = 24'({halfCnt, 1'b0});
	// Brake settings override during brake half cycles.
	assign brakeActive = (brakeLeft != 4'h0);
	assign gainEff  = brakeActive ? brakeQ[POS_BRK_GAIN +: 4] : brakeQ[POS_NRM_GAIN +: 4];
	assign wdwEff   = brakeActive ? brakeQ[POS_BRK_WDW +: 4] : brakeQ[POS_NRM_WDW +: 4];

	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			periodQ   <= 24'h000000;
			segCnt    <= 18'h00000;
			idxQ      <= 6'h00;
			halfCnt   <= 24'h000000;
			prevSign  <= 1'b0;
			dirPrev   <= 1'b0;
			brakeLeft <= 4'h0;
		end
		else
		begin
			segCnt  <= (segCnt == 18'h00000) ? periodQ[23:6] : segCnt - 18'h00001;
			idxQ    <= (segCnt == 18'h00000) ? idxQ + 6'h01 : idxQ;
			dirPrev <= driveQ[BIT_DIR];
			if (driveQ[BIT_DIR] != dirPrev)
				brakeLeft <= brakeQ[POS_BRK_CYC +: 4];
			else if (halfEnd && brakeActive)
				brakeLeft <= brakeLeft - 4'h1;
			if (bemfStrobe)
				prevSign <= bemfD2[7];
			halfCnt <= crossing ? 24'h000000 : halfCnt + 24'h000001;
			// Crossings outside the blanking window steer the period.
			if (!(ctrlQ[BIT_TRACK] && isLra && driving))
				periodQ <= clampPer(24'(guessQ[11:0] * CYC_INIT), loPer, hiPer);
			else if (crossing && idxQ[4:0] >= {1'b0, wdwEff})
				periodQ <= clampPer(24'($signed({1'b0, periodQ}) +
					($signed({1'b0, measPer} - {1'b0, periodQ}) >>> gainEff)), loPer, hiPer);
			else
				periodQ <= clampPer(periodQ, loPer, hiPer);
		end
	end

	// Brake sample or triggered brake amplitude arms measuring.
	assign brakeSample = isLra && ((ctrlQ[BIT_RAM] && driveQ[POS_SCODE +: 2] == 2'h0 &&
		driveQ[POS_SRPT +: 4] == 4'h0) || (ctrlQ[BIT_TRG] && ctrlQ[BIT_BRKAMP]));
	// Two points on the peaks or four on the quarter points.
	assign pointHit = (segCnt == 18'h00000) &&
		(ctrlQ[BIT_POINTS] ? (idxQ[3:0] == 4'h7) : (idxQ[4:0] == 5'h0f));
	assign lowNow   = (((bemfD2[7] ? 8'(-bemfD2) : bemfD2) < abrkQ[POS_AB_THR +: 8])) ?
		8'h01 : 8'h00;

	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			winLeft  <= 8'h00;
			lowCnt   <= 8'h00;
			quietRun <= 4'h0;
			abStopQ  <= 1'b0;
		end
		else if (!brakeSample || !ctrlQ[BIT_DRIVE])
		begin
			winLeft  <= 8'h00;
			lowCnt   <= 8'h00;
			quietRun <= 4'h0;
			abStopQ  <= 1'b0;
		end
		else if (pointHit && winLeft == 8'h00)
		begin
			winLeft <= abrkQ[POS_AB_WDW +: 8];
			lowCnt  <= 8'h00;
		end
		else if (bemfStrobe && winLeft != 8'h00)
		begin
			winLeft <= winLeft - 8'h01;
			lowCnt  <= lowCnt + lowNow;
			// Quiet point needs more than half the window low.
			if (winLeft == 8'h01)
			begin
				if (lowCnt + lowNow > {1'b0, abrkQ[POS_AB_WDW + 1 +: 7]})
				begin
					quietRun <= quietRun + 4'h1;
					if (quietRun + 4'h1 >= abrkQ[POS_AB_CONS +: 4])
						abStopQ <= 1'b1;
				end
				else
					quietRun <= 4'h0;
			end
		end
	end

	// Compensation scales the target level by the measured supply.
	assign target   = 8'((16'(driveQ[POS_AMP +: 7]) * 16'(driveQ[POS_VFS +: 8])) >> 7);
	assign dutyWide = (supplyQ == 8'h00) ? 16'h00ff : (16'(target) * 16'h00ff) / 16'(supplyQ);
	assign duty     = ctrlQ[BIT_ALC] ? ((dutyWide > 16'h00ff) ? 8'hff : dutyWide[7:0]) :
		{driveQ[POS_AMP +: 7], 1'b0};
	// Linear mode shapes the level by the sine table.
	assign mag      = isLra ? 8'((16'(duty) * 16'(sineAt(idxQ))) >> 8) : duty;
	// Rotating-mass direction follows the direction bit.
	assign polPos   = isLra ? (idxQ[5] == driveQ[BIT_DIR]) : !driveQ[BIT_DIR];

	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			pwmCnt <= 8'h00;
			drvP   <= 1'b0;
			drvN   <= 1'b0;
		end
		else
		begin
			pwmCnt <= pwmCnt + 8'h01;
			// Bridge legs switch with the chosen waveform.
			drvP   <= driving && polPos && (pwmCnt < mag);
			drvN   <= driving && !polPos && (pwmCnt < mag);
		end
	end
endmodule

/* File: haptic_checker_assertions.sv */
`timescale 1ns/1ps
module haptic_checker
	import haptic_adc_pkg::*;
#(
	parameter int PER_MAX  = PER_MAX_CYC,
	parameter int PER_MIN  = PER_MIN_CYC,
	parameter int POLL_MAX = POLL_CYC
)(
	input wire logic        ref_clk,
	input wire logic        rst_n,
	input wire logic        wb_cyc_i,
	input wire logic        wb_stb_i,
	input wire logic        wb_we_i,
	input wire logic [7:0]  wb_adr_i,
	input wire logic [3:0]  wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic        wb_ack_o,
	input wire logic        adcStart,
	input wire logic [2:0]  adcChannel,
	input wire logic        adcReady,
	input wire logic [7:0]  adcData,
	input wire logic        bemfValid,
	input wire logic [7:0]  bemfData,
	input wire logic        drvP,
	input wire logic        drvN
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	logic req;
	assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
	ack_follows_a: assert property (req |=> wb_ack_o)
		else $error("ack missing one cycle after a request");
	ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack held longer than one cycle");
	idle_data_zero_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
		else $error("read data not zero outside ack");
	unmapped_zero_a: assert property (req && !wb_we_i && wb_adr_i > 8'h20 |=> ~|wb_dat_o)
		else $error("unmapped read returned data");
	// A shoot-through on the bridge would short the supply.
	legs_exclusive_a: assert property (!(drvP && drvN))
		else $error("both bridge legs on");
	start_gap_a: assert property (adcStart |=> !adcStart [*3])
		else $error("converter start repeated too soon");
	channel_held_a: assert property (adcStart |=> $stable(adcChannel) [*2])
		else $error("channel changed during a conversion");
	reset_quiet_a: assert property ($rose(rst_n) |-> !drvP && !drvN && !wb_ack_o && !adcStart)
		else $error("outputs active right after reset");
endmodule
bind haptic_drive_and_adc_control haptic_checker #(.PER_MAX(PER_MAX), .PER_MIN(PER_MIN),
	.POLL_MAX(POLL_MAX)) haptic_checker_i (.ref_clk(ref_clk), .rst_n(rst_n),
	.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
	.wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
	.adcStart(adcStart), .adcChannel(adcChannel), .adcReady(adcReady), .adcData(adcData),
	.bemfValid(bemfValid), .bemfData(bemfData), .drvP(drvP), .drvN(drvN));

/* File: haptic_actuator_model.sv */
`timescale 1ns/1ps
module haptic_actuator_model (
	input  wire logic       ref_clk,
	input  wire logic       adcStart,
	input  wire logic [7:0] bemfAmp,
	input  wire logic [7:0] bemfHalf,
	output logic            adcReady,
	output logic      [7:0] adcData,
	output logic            bemfValid,
	output logic      [7:0] bemfData
);
	logic [7:0] samples[$];
	int         startCnt = 0;
	int         servedCnt = 0;
	logic [7:0] bemfCnt = 8'h00;
	logic [7:0] flipCnt = 8'h00;
	logic       sign = 1'b0;
	initial
	begin
		adcReady = 1'b0;
		adcData = 8'h00;
		bemfValid = 1'b0;
		bemfData = 8'h00;
	end
	always @(posedge ref_clk)
		if (adcStart)
			startCnt <= startCnt + 1;
	// Data is set before ready rises and held well past it, then scrambled.
	always
	begin
		@(posedge ref_clk);
		if (servedCnt != startCnt)
		begin
			repeat (3) @(posedge ref_clk);
			adcData <= samples.size() > 0 ? samples.pop_front() : 8'hc8;
			@(posedge ref_clk);
			adcReady <= 1'b1;
			repeat (6) @(posedge ref_clk);
			adcReady <= 1'b0;
			servedCnt++;
			@(posedge ref_clk);
			adcData <= ~adcData;
		end
	end
	always @(posedge ref_clk)
	begin
		bemfCnt <= bemfCnt + 8'h01;
		bemfValid <= bemfCnt[2];
		if (bemfCnt[2:0] == 3'h0)
		begin
			flipCnt <= (flipCnt >= bemfHalf) ? 8'h00 : flipCnt + 8'h01;
			if (flipCnt >= bemfHalf)
				sign <= ~sign;
			bemfData <= sign ? 8'h00 - bemfAmp : bemfAmp;
		end
	end
endmodule

/* File: haptic_drive_and_adc_control_tb_top.sv */
`timescale 1ns/1ps
module haptic_drive_and_adc_control_tb_top
	import haptic_adc_pkg::*;
;
	localparam int          PMAX = 2000;
	localparam int          PMIN = 200;
	localparam int          POLL = 50;
	localparam logic [31:0] ALL  = 32'hffff_ffff;
	logic        clk = 1'b0;
	logic        rstN = 1'b0;
	logic        cyc = 1'b0;
	logic        stb = 1'b0;
	logic        we = 1'b0;
	logic [7:0]  adr = 8'h00;
	logic [3:0]  sel = 4'h0;
	logic [31:0] datW = 32'h0;
	logic [31:0] datR;
	logic        ack;
	logic        adcStart;
	logic [2:0]  adcChannel;
	logic        adcReady;
	logic [7:0]  adcData;
	logic        bemfValid;
	logic [7:0]  bemfData;
	logic        drvP;
	logic        drvN;
	logic [7:0]  bemfAmp = 8'h40;
	logic [7:0]  bemfHalf = 8'h01;
	logic [2:0]  startChan = 3'h0;
	logic [31:0] r;
	int          failCount = 0;
	int          comparisons = 0;
	int          starts = 0;
	int          pCnt = 0;
	int          nCnt = 0;
	always #2.5 clk = ~clk;
	always @(posedge clk)
	begin
		starts <= starts + int'(adcStart);
		if (adcStart)
			startChan <= adcChannel;
		pCnt <= pCnt + int'(drvP);
		nCnt <= nCnt + int'(drvN);
	end
	haptic_drive_and_adc_control #(.PER_MAX(PMAX), .PER_MIN(PMIN), .POLL_MAX(POLL))
		haptic_drive_and_adc_control_i (
		.ref_clk(clk), .rst_n(rstN), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(datW), .wb_dat_o(datR), .wb_ack_o(ack),
		.adcStart(adcStart), .adcChannel(adcChannel), .adcReady(adcReady),
		.adcData(adcData), .bemfValid(bemfValid), .bemfData(bemfData),
		.drvP(drvP), .drvN(drvN));
	haptic_actuator_model haptic_actuator_model_i (.ref_clk(clk), .adcStart(adcStart),
		.bemfAmp(bemfAmp), .bemfHalf(bemfHalf), .adcReady(adcReady), .adcData(adcData),
		.bemfValid(bemfValid), .bemfData(bemfData));
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			failCount++;
			$display("[FAIL] t=%0t seen=%h expected=%h", $time, got, exp);
		end
	endtask
	task automatic xfer(input logic w, input logic [7:0] a, input logic [3:0] s,
		input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		sel <= s;
		datW <= d;
		do
			@(posedge clk);
		while (ack !== 1'b1 && n++ < 100);
		if (n >= 100)
			failCount++;
		r = datR;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		xfer(1'b1, a, 4'hf, d);
	endtask
	task automatic rdChk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		xfer(1'b0, a, 4'hf, 32'h0);
		check(r & m, e);
	endtask
	function automatic logic [15:0] fsOf(input logic [2:0] ch);
		return (ch <= CH_MONITOR) ? FS_LOW_MV : (ch == CH_BOOST) ? FS_HIGH_MV : FS_MID_MV;
	endfunction
	task automatic conclude();
		$display("Counts: comparisons=%0d mismatches=%0d", comparisons, failCount);
		if (failCount == 0 && comparisons > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	initial
	begin
		#500000;
		failCount++;
		conclude();
	end
	initial
	begin
		logic [7:0]  s;
		logic [7:0]  mn;
		logic [7:0]  mx;
		logic [1:0]  avg;
		logic [31:0] cfg;
		int          sum;
		int          k;
		int          base;
		int          lo;
		int          hi;
		int          g;
		void'($urandom(32'h5cf1));
		repeat (10) @(posedge clk);
		rstN <= 1'b1;
		rdChk(OFS_CTRL, ALL, CTRL_RST);
		rdChk(OFS_GUESS, ALL, GUESS_RST);
		rdChk(OFS_BRAKE, ALL, BRAKE_RST);
		rdChk(OFS_ABRK, ALL, ABRK_RST);
		rdChk(OFS_ADC_CTRL, ALL, ADC_CTRL_RST);
		xfer(1'b1, OFS_DRIVE, 4'h1, 32'h1234_5678);
		rdChk(OFS_DRIVE, ALL, 32'hff00_0078);
		wr(8'h40, ALL);
		rdChk(8'h40, ALL, 32'h0);
		$display("Test registers done");
		for (int i = 0; i < 6; i++)
		begin
			avg = 2'($urandom_range(2));
			cfg = (32'(avg) << POS_AVG) | 32'(i % 5);
			mn = 8'hff;
			mx = 8'h00;
			sum = 0;
			for (k = 0; k < (1 << avg); k++)
			begin
				s = 8'($urandom);
				haptic_actuator_model_i.samples.push_back(s);
				sum += s;
				mn = (s < mn) ? s : mn;
				mx = (s > mx) ? s : mx;
			end
			base = starts;
			wr(OFS_ADC_CTRL, cfg);
			wr(OFS_ADC_CTRL, cfg | 32'h100);
			// The second launch lands while busy and must not add samples.
			wr(OFS_ADC_CTRL, cfg | 32'h100);
			k = 0;
			do
				xfer(1'b0, OFS_ADC_STAT, 4'hf, 32'h0);
			while (r[BIT_DONE] !== 1'b1 && k++ < 200);
			check(r & 32'hffff_0003, {fsOf(cfg[2:0]), 16'h1});
			check(32'(starts - base), 32'(1 << avg));
			check(32'(startChan), cfg & 32'h7);
			rdChk(OFS_ADC_RES, 32'h00ff_ffff, {8'h0, mx, mn, 8'(sum >> avg)});
			rdChk(OFS_ADC_STAT, 32'h1, 32'h1);
			wr(OFS_ADC_STAT, 32'h1);
			rdChk(OFS_ADC_STAT, 32'h1, 32'h0);
		end
		wr(OFS_ADC_CTRL, 32'h0001_0001);
		rdChk(OFS_ADC_STAT, 32'h4, 32'h4);
		wr(OFS_ADC_CTRL, 32'h0000_0001);
		rdChk(OFS_ADC_STAT, 32'h4, 32'h0);
		$display("Test converter done");
		for (int d = 0; d < 2; d++)
		begin
			wr(OFS_DRIVE, 32'hff00_0000 | 32'(d << BIT_DIR) | 32'($urandom_range(127, 16)));
			wr(OFS_CTRL, 32'h42);
			repeat (300) @(posedge clk);
			base = pCnt;
			k = nCnt;
			repeat (512) @(posedge clk);
			check(32'(pCnt > base), 32'(d == 0));
			check(32'(nCnt > k), 32'(d == 1));
		end
		wr(OFS_DRIVE, 32'hff00_007f);
		for (int i = 0; i < 4; i++)
		begin
			g = (i < 2) ? 1 : 4;
			lo = (g * 250 > PMIN) ? g * 250 : PMIN;
			hi = (g * 1000 < PMAX) ? g * 1000 : PMAX;
			bemfHalf <= i[0] ? 8'hff : 8'h01;
			wr(OFS_GUESS, 32'(g));
			wr(OFS_CTRL, 32'h43);
			base = pCnt;
			k = nCnt;
			repeat (6000) @(posedge clk);
			check(32'(pCnt > base && nCnt > k), 32'h1);
			xfer(1'b0, OFS_TRACK, 4'hf, 32'h0);
			check(32'((int'(r[21:0]) << 2) + 3 >= lo), 32'h1);
			check(32'((int'(r[21:0]) << 2) <= hi), 32'h1);
		end
		wr(OFS_DRIVE, 32'hff00_00ff);
		k = 0;
		do
			xfer(1'b0, OFS_TRACK, 4'hf, 32'h0);
		while (r[22] !== 1'b1 && k++ < 50);
		check(32'(r[22]), 32'h1);
		$display("Test drive done");
		bemfAmp <= 8'h00;
		for (int i = 0; i < 2; i++)
		begin
			wr(OFS_CTRL, 32'h1);
			wr(OFS_CTRL, i ? 32'hd3 : 32'h6b);
			k = 0;
			do
			begin
				repeat (40) @(posedge clk);
				xfer(1'b0, OFS_TRACK, 4'hf, 32'h0);
			end
			while (r[23] !== 1'b1 && k++ < 200);
			check(32'(r[23]), 32'h1);
			base = pCnt + nCnt;
			repeat (300) @(posedge clk);
			check(32'(pCnt + nCnt - base), 32'h0);
		end
		$display("Test autobrake done");
		wr(OFS_CTRL, 32'h46);
		base = starts;
		repeat (POLL * 6) @(posedge clk);
		check(32'(starts > base), 32'h1);
		rdChk(OFS_ADC_RES, 32'hff00_0000, 32'hc800_0000);
		base = nCnt;
		repeat (256) @(posedge clk);
		check(32'(nCnt - base >= 250), 32'h1);
		rdChk(OFS_ADC_STAT, 32'h1, 32'h0);
		$display("Test compensation done");
		conclude();
	end
endmodule
